// [inc/rpl_map.svh]
/*
 Register offsets, field positions, reset values and timing for the
 receive-port link control register bank.
 Guarded against repeated inclusion; assumes it is included by its bare name.
*/
// Contract
// - Bit 7 of the encoder control register turns encoder CRC checking on when 0, off when 1.
// - In raw mode a frame-begin packet goes out once the frame marker has stayed high the programmed count.
// - A pin's pulldown is on whenever the pin is not in an output mode, unless disabled.
// - Seven disable bits, one per pin 0 to 6, turn their pulldown off when 1 and reset to 0.
// - Bit 5 of the port debug register reads whether the remote serializer is in self-test.
// - With continuous injection set, every outgoing back-channel frame gets one bit corrupted.
// - Setting single injection corrupts one bit of exactly one outgoing back-channel frame.
// - The equalizer waits a 3-bit-coded time for lock, 164 us doubling per code, before stepping.
// - With first-lock control 1, initial lock restarts adaptation at setting 0.
// - Writing 1 to restart bit 3 restarts adaptation and the bit clears itself.
// - With the floor control set, adaptation starts at the floor setting instead of zero.
// - Port registers exist once per receive port, reached through the port-select register.
// - The floor setting comes from a 4-bit field that resets to 0x2.
// - With the encoder CRC on, link information from packets failing CRC is not taken.
`ifndef RPL_MAP_SVH
`define RPL_MAP_SVH

`define RPL_NUM_PORTS 2
`define RPL_NUM_PINS 7

// register offsets
`define RPL_A_PORT_SEL 8'h4C
`define RPL_A_ENC_CTL 8'hBA
`define RPL_A_RSV_BB 8'hBB
`define RPL_A_MIN_TIME 8'hBC
`define RPL_A_RSV_BD 8'hBD
`define RPL_A_PD_CTL 8'hBE
`define RPL_A_RSV_BF 8'hBF
`define RPL_A_DEBUG 8'hD0
`define RPL_A_RSV_D1 8'hD1
`define RPL_A_EQ_CTL 8'hD2
`define RPL_A_EQ_LIM 8'hD5

// reset values
`define RPL_R_PORT_SEL 8'h01
`define RPL_R_ENC_CTL 8'h03
`define RPL_R_RSV_BB 8'h74
`define RPL_R_MIN_TIME 8'h80
`define RPL_R_RSV_BD 8'h00
`define RPL_R_PD_CTL 8'h00
`define RPL_R_RSV_BF 8'h00
`define RPL_R_DEBUG 8'h00
`define RPL_R_RSV_D1 8'h43
`define RPL_R_EQ_CTL 8'h94
`define RPL_R_EQ_LIM 8'hF2

// bits software may change; the rest hold their reset value
`define RPL_M_PORT_SEL 8'h13
`define RPL_M_ENC_CTL 8'h80
`define RPL_M_PD_CTL 8'h7F
`define RPL_M_DEBUG 8'h03
`define RPL_M_EQ_CTL 8'hF4
`define RPL_M_EQ_LIM 8'hFF

// field positions
`define RPL_PSEL_RD_BIT 4
`define RPL_ENC_OFF_BIT 7
`define RPL_DBG_SELFTEST_BIT 5
`define RPL_DBG_CONT_BIT 1
`define RPL_DBG_ONCE_BIT 0
`define RPL_EQ_WAIT_MSB 7
`define RPL_EQ_WAIT_LSB 5
`define RPL_EQ_FIRST_BIT 4
`define RPL_EQ_RERUN_BIT 3
`define RPL_EQ_FLOOR_BIT 2
`define RPL_LIM_MAX_MSB 7
`define RPL_LIM_MAX_LSB 4
`define RPL_LIM_FLOOR_MSB 3
`define RPL_LIM_FLOOR_LSB 0

// timing
`define RPL_MCLK_PERIOD_NS 40
`define RPL_EQ_WAIT_BASE_NS 164000
`define RPL_EQ_CNT_W 20

`endif

// [inc/rpl_pkg.sv]
/*
 Types of the receive-port link control register bank.
 Assumes rpl_map.svh is on the include path.
*/
`include "rpl_map.svh"

package rpl_pkg;

   // per receive port state
   typedef struct packed {
      logic [7:0] dbg;
      logic [7:0] eqctl;
      logic [7:0] eqlim;
      logic once_done;
      logic flip;
      logic mismatch;
      logic lock_prev;
      logic first_seen;
      logic [3:0] eq_set;
      logic [`RPL_EQ_CNT_W-1:0] wait_cnt;
   } rpl_port_t;

   // host register access strobes with data
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rpl_acc_t;

   // whole state of the bank
   typedef struct packed {
      logic [7:0] psel;
      logic [7:0] enc;
      logic [7:0] mintime;
      logic [7:0] pd;
      logic [7:0] rdata;
      logic [7:0] link_info;
      logic [7:0] raw_cnt;
      logic raw_done;
      logic fbp;
      logic [`RPL_NUM_PINS-1:0] pulldown_on;
      rpl_port_t [`RPL_NUM_PORTS-1:0] port;
   } rpl_state_t;

endpackage : rpl_pkg

// [rtl/rpl_port_regs.sv]
/*
 Receive-port link control register bank: encoder CRC gate, raw-mode
 frame-begin timing, pin pulldowns, back-channel error injection,
 remote self-test flag and equalizer adaptation per receive port.
 Assumes an upstream serial target turns host transactions into one-cycle
 access strobes, all inputs synchronous to mclk, and that link clock
 periods are counted in mclk cycles.
*/
`include "rpl_map.svh"

module rpl_port_regs #(
   parameter int EQ_WAIT_BASE_CYC = `RPL_EQ_WAIT_BASE_NS / `RPL_MCLK_PERIOD_NS
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire rpl_pkg::rpl_acc_t acc,
   output logic [7:0] reg_rdata,
   input wire logic enc_pkt_valid,
   input wire logic enc_pkt_crc_ok,
   input wire logic [7:0] enc_pkt_info,
   output logic [7:0] link_info,
   input wire logic raw_mode,
   input wire logic raw_frame_marker,
   output logic frame_begin_packet,
   input wire logic [`RPL_NUM_PINS-1:0] pin_output_mode,
   output logic [`RPL_NUM_PINS-1:0] pulldown_on,
   input wire logic local_selftest,
   input wire logic [`RPL_NUM_PORTS-1:0] remote_selftest_active,
   output logic [`RPL_NUM_PORTS-1:0] selftest_mismatch,
   input wire logic [`RPL_NUM_PORTS-1:0] bc_frame_start,
   output logic [`RPL_NUM_PORTS-1:0] bc_bit_flip,
   input wire logic [`RPL_NUM_PORTS-1:0] rx_lock,
   output logic [`RPL_NUM_PORTS*4-1:0] eq_setting
);

   rpl_pkg::rpl_state_t s_q;
   rpl_pkg::rpl_state_t s_d;
   logic [`RPL_NUM_PORTS-1:0] rerun_hit;
   logic [`RPL_EQ_CNT_W-1:0] lim [`RPL_NUM_PORTS];
   logic [3:0] start_set [`RPL_NUM_PORTS];
   logic rd_port;

   localparam logic [`RPL_EQ_CNT_W-1:0] WAIT_BASE = `RPL_EQ_CNT_W'(EQ_WAIT_BASE_CYC);

   assign rd_port = s_q.psel[`RPL_PSEL_RD_BIT];

   // next state of the whole bank
   always_comb begin
      s_d = s_q;
      // control writes; a masked merge keeps reserved bits at their reset value
      if (acc.wr) begin
         case (acc.addr)
            `RPL_A_PORT_SEL: s_d.psel = (acc.wdata & `RPL_M_PORT_SEL) |
               (`RPL_R_PORT_SEL & ~`RPL_M_PORT_SEL);
            `RPL_A_ENC_CTL: s_d.enc = (acc.wdata & `RPL_M_ENC_CTL) |
               (`RPL_R_ENC_CTL & ~`RPL_M_ENC_CTL);
            `RPL_A_MIN_TIME: s_d.mintime = acc.wdata;
            `RPL_A_PD_CTL: s_d.pd = acc.wdata & `RPL_M_PD_CTL;
            default: s_d.psel = s_q.psel;
         endcase
      end
      // register read answers one cycle after the strobe
      if (acc.rd) begin
         case (acc.addr)
            `RPL_A_PORT_SEL: s_d.rdata = s_q.psel;
            `RPL_A_ENC_CTL: s_d.rdata = s_q.enc;
            `RPL_A_RSV_BB: s_d.rdata = `RPL_R_RSV_BB;
            `RPL_A_MIN_TIME: s_d.rdata = s_q.mintime;
            `RPL_A_RSV_BD: s_d.rdata = `RPL_R_RSV_BD;
            `RPL_A_PD_CTL: s_d.rdata = s_q.pd;
            `RPL_A_RSV_BF: s_d.rdata = `RPL_R_RSV_BF;
            `RPL_A_DEBUG: begin
               s_d.rdata = s_q.port[rd_port].dbg;
               s_d.rdata[`RPL_DBG_SELFTEST_BIT] = remote_selftest_active[rd_port];
            end
            `RPL_A_RSV_D1: s_d.rdata = `RPL_R_RSV_D1;
            `RPL_A_EQ_CTL: s_d.rdata = s_q.port[rd_port].eqctl;
            `RPL_A_EQ_LIM: s_d.rdata = s_q.port[rd_port].eqlim;
            default: s_d.rdata = 8'h00;
         endcase
      end
      // encoded packet info is dropped on a failed CRC unless checking is off
      if (enc_pkt_valid && (enc_pkt_crc_ok || s_q.enc[`RPL_ENC_OFF_BIT])) begin
         s_d.link_info = enc_pkt_info;
      end
      // raw mode frame marker qualification
      s_d.fbp = 1'b0;
      if (raw_mode && raw_frame_marker) begin
         if (s_q.raw_cnt != 8'hFF) begin
            s_d.raw_cnt = s_q.raw_cnt + 8'h01;
         end
         if (!s_q.raw_done && (s_d.raw_cnt >= s_q.mintime)) begin
            s_d.fbp = 1'b1;
            s_d.raw_done = 1'b1;
         end
      end else begin
         s_d.raw_cnt = 8'h00;
         s_d.raw_done = 1'b0;
      end
      // pulldown follows pin mode and its disable bit
      s_d.pulldown_on = ~pin_output_mode & ~s_q.pd[`RPL_NUM_PINS-1:0];
      // per receive port logic
      for (int p = 0; p < `RPL_NUM_PORTS; p++) begin
         if (acc.wr && s_q.psel[p]) begin
            case (acc.addr)
               `RPL_A_DEBUG: s_d.port[p].dbg = acc.wdata & `RPL_M_DEBUG;
               `RPL_A_EQ_CTL: s_d.port[p].eqctl = acc.wdata & `RPL_M_EQ_CTL;
               `RPL_A_EQ_LIM: s_d.port[p].eqlim = acc.wdata & `RPL_M_EQ_LIM;
               default: s_d.port[p].dbg = s_q.port[p].dbg;
            endcase
         end
         s_d.port[p].mismatch = remote_selftest_active[p] && !local_selftest;
         // injection; the one-shot rearms only once software drops the bit
         s_d.port[p].flip = 1'b0;
         if (bc_frame_start[p]) begin
            if (s_q.port[p].dbg[`RPL_DBG_CONT_BIT]) begin
               s_d.port[p].flip = 1'b1;
            end
            if (s_q.port[p].dbg[`RPL_DBG_ONCE_BIT] && !s_q.port[p].once_done) begin
               s_d.port[p].flip = 1'b1;
               s_d.port[p].once_done = 1'b1;
            end
         end
         if (!s_q.port[p].dbg[`RPL_DBG_ONCE_BIT]) begin
            s_d.port[p].once_done = 1'b0;
         end
         // equalizer stepping
         s_d.port[p].lock_prev = rx_lock[p];
         if (rerun_hit[p]) begin
            s_d.port[p].eq_set = start_set[p];
            s_d.port[p].wait_cnt = '0;
            s_d.port[p].first_seen = 1'b0;
         end else if (rx_lock[p] && !s_q.port[p].lock_prev && !s_q.port[p].first_seen) begin
            s_d.port[p].first_seen = 1'b1;
            s_d.port[p].wait_cnt = '0;
            if (s_q.port[p].eqctl[`RPL_EQ_FIRST_BIT]) begin
               s_d.port[p].eq_set = 4'h0;
            end
         end else if (!rx_lock[p]) begin
            s_d.port[p].wait_cnt = s_q.port[p].wait_cnt + `RPL_EQ_CNT_W'(1);
            if (s_d.port[p].wait_cnt >= lim[p]) begin
               s_d.port[p].wait_cnt = '0;
               if (s_q.port[p].eq_set >= s_q.port[p].eqlim[`RPL_LIM_MAX_MSB:`RPL_LIM_MAX_LSB])
               begin
                  s_d.port[p].eq_set = start_set[p];
               end else begin
                  s_d.port[p].eq_set = s_q.port[p].eq_set + 4'h1;
               end
            end
         end else begin
            s_d.port[p].wait_cnt = '0;
         end
      end
   end

   // per port decode helpers, also watched by the checks below
   generate
      for (genvar g = 0; g < `RPL_NUM_PORTS; g++) begin : g_port
         // restart bit is never stored, so it always reads back as 0
         assign rerun_hit[g] = acc.wr && s_q.psel[g] && (acc.addr == `RPL_A_EQ_CTL) &&
            acc.wdata[`RPL_EQ_RERUN_BIT];
         // 164 us doubled per code; later codes round the printed figures
         assign lim[g] = WAIT_BASE <<
            s_q.port[g].eqctl[`RPL_EQ_WAIT_MSB:`RPL_EQ_WAIT_LSB];
         assign start_set[g] = s_q.port[g].eqctl[`RPL_EQ_FLOOR_BIT] ?
            s_q.port[g].eqlim[`RPL_LIM_FLOOR_MSB:`RPL_LIM_FLOOR_LSB] : 4'h0;
         assign selftest_mismatch[g] = s_q.port[g].mismatch;
         assign bc_bit_flip[g] = s_q.port[g].flip;
         assign eq_setting[g*4 +: 4] = s_q.port[g].eq_set;
      end
   endgenerate

   // state register with constant reset values
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.psel <= `RPL_R_PORT_SEL;
         s_q.enc <= `RPL_R_ENC_CTL;
         s_q.mintime <= `RPL_R_MIN_TIME;
         s_q.pd <= `RPL_R_PD_CTL;
         s_q.pulldown_on <= '1;
         for (int p = 0; p < `RPL_NUM_PORTS; p++) begin
            s_q.port[p].dbg <= `RPL_R_DEBUG;
            s_q.port[p].eqctl <= `RPL_R_EQ_CTL;
            s_q.port[p].eqlim <= `RPL_R_EQ_LIM;
            s_q.port[p].eq_set <= 4'(`RPL_R_EQ_LIM); // floor field is the low nibble
         end
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state flops
   assign reg_rdata = s_q.rdata;
   assign link_info = s_q.link_info;
   assign frame_begin_packet = s_q.fbp;
   assign pulldown_on = s_q.pulldown_on;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   property p_pd_output_mode;
      pin_output_mode[0] |=> !pulldown_on[0];
   endproperty
   a_pd_output_mode: assert property (p_pd_output_mode) else $error("pulldown on in output mode");

   property p_pd_disable;
      (!pin_output_mode[1] && !s_q.pd[1]) |=> pulldown_on[1];
   endproperty
   a_pd_disable: assert property (p_pd_disable) else $error("enabled pulldown stayed off");

   property p_fbp_cause;
      frame_begin_packet |-> $past(raw_mode) && $past(raw_frame_marker) &&
         ($past(s_q.raw_cnt) + 9'h001 >= {1'b0, $past(s_q.mintime)});
   endproperty
   a_fbp_cause: assert property (p_fbp_cause) else $error("frame begin without qualified marker");

   property p_crc_block;
      (enc_pkt_valid && !enc_pkt_crc_ok && !s_q.enc[`RPL_ENC_OFF_BIT]) |=> $stable(link_info);
   endproperty
   a_crc_block: assert property (p_crc_block) else $error("failed packet updated link info");

   property p_inject_cont;
      (bc_frame_start[0] && s_q.port[0].dbg[`RPL_DBG_CONT_BIT]) |=> bc_bit_flip[0];
   endproperty
   a_inject_cont: assert property (p_inject_cont) else $error("continuous injection missed");

   property p_inject_once;
      (bc_frame_start[0] && s_q.port[0].dbg[`RPL_DBG_ONCE_BIT] && !s_q.port[0].once_done)
         |=> bc_bit_flip[0] ##1 !bc_bit_flip[0] || s_q.port[0].dbg[`RPL_DBG_CONT_BIT] ||
         $past(bc_frame_start[0]);
   endproperty
   a_inject_once: assert property (p_inject_once) else $error("single injection wrong");

   property p_once_hold;
      (s_q.port[0].once_done && !s_q.port[0].dbg[`RPL_DBG_CONT_BIT] &&
         s_q.port[0].dbg[`RPL_DBG_ONCE_BIT]) |=> !bc_bit_flip[0];
   endproperty
   a_once_hold: assert property (p_once_hold) else $error("second single injection");

   property p_rerun;
      (rerun_hit[0] && !rx_lock[0]) |=> (eq_setting[3:0] == $past(start_set[0])) &&
         !s_q.port[0].eqctl[`RPL_EQ_RERUN_BIT];
   endproperty
   a_rerun: assert property (p_rerun) else $error("restart did not load start setting");

   property p_wait_bound;
      s_q.port[0].wait_cnt == lim[0] - `RPL_EQ_CNT_W'(1) |=> s_q.port[0].wait_cnt == '0;
   endproperty
   a_wait_bound: assert property (p_wait_bound) else $error("equalizer wait overran");

   property p_first_lock;
      (rx_lock[0] && !s_q.port[0].lock_prev && !s_q.port[0].first_seen && !rerun_hit[0] &&
         s_q.port[0].eqctl[`RPL_EQ_FIRST_BIT]) |=> eq_setting[3:0] == 4'h0;
   endproperty
   a_first_lock: assert property (p_first_lock) else $error("first lock did not zero");

   property p_mismatch;
      (remote_selftest_active[1] && !local_selftest) |=> selftest_mismatch[1];
   endproperty
   a_mismatch: assert property (p_mismatch) else $error("self-test mismatch not flagged");

   property p_rd_selftest;
      (acc.rd && acc.addr == `RPL_A_DEBUG) |=>
         reg_rdata[`RPL_DBG_SELFTEST_BIT] == $past(remote_selftest_active[rd_port]);
   endproperty
   a_rd_selftest: assert property (p_rd_selftest) else $error("self-test flag misread");

   property p_port_isolation;
      (acc.wr && acc.addr == `RPL_A_EQ_CTL && !s_q.psel[1]) |=> $stable(s_q.port[1].eqctl);
   endproperty
   a_port_isolation: assert property (p_port_isolation) else $error("unselected port written");

   // main scenarios
   property p_cv_fbp;
      raw_mode ##1 frame_begin_packet;
   endproperty
   c_cv_fbp: cover property (p_cv_fbp);

   property p_cv_once;
      bc_bit_flip[0] && !s_q.port[0].dbg[`RPL_DBG_CONT_BIT];
   endproperty
   c_cv_once: cover property (p_cv_once);

   property p_cv_step;
      !rx_lock[1] ##1 $changed(eq_setting[7:4]);
   endproperty
   c_cv_step: cover property (p_cv_step);

endmodule : rpl_port_regs

// [verification/rpl_remote_ser.sv]
/*
 Behavioural remote serializer facing the receive-port bank: self-test
 state and back-channel frame starts for both ports.
 Assumes the bench raises its requests just after falling edges of mclk.
*/
module rpl_remote_ser (
   input wire logic mclk,
   input wire logic [1:0] selftest_req,
   input wire logic [1:0] send_req,
   output logic [1:0] remote_selftest_active,
   output logic [1:0] bc_frame_start
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [1:0] st_q;
   logic [1:0] send_q;

   // idle at time zero, before the first falling edge
   initial begin
      remote_selftest_active = 2'b00;
      bc_frame_start = 2'b00;
   end

   // requests taken on rising edges, clear of the bench's falling-edge updates
   always @(posedge mclk) begin
      st_q <= selftest_req;
      send_q <= send_req;
   end

   // launch on falling edges so the bank samples settled levels
   always @(negedge mclk) begin
      remote_selftest_active <= st_q;
      bc_frame_start <= send_q; // one cycle per requested frame
   end
endmodule : rpl_remote_ser

// [verification/rpl_port_regs_tb.sv]
/*
 Self-checking bench for the receive-port link control bank.
 Assumes rpl_pkg is compiled first and rpl_remote_ser is available.
*/
module rpl_port_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BASE = 4;
   localparam logic [7:0] RA [12] = '{8'h4C, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF,
      8'hD0, 8'hD1, 8'hD2, 8'hD5, 8'h00};
   localparam logic [7:0] RV [12] = '{8'h01, 8'h03, 8'h74, 8'h80, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h43, 8'h94, 8'hF2, 8'h00};
   localparam logic [7:0] WA [8] = '{8'hBA, 8'hBB, 8'hBD, 8'hBE, 8'hBF, 8'hD0, 8'hD1, 8'hD2};
   localparam logic [7:0] WD [8] = '{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF};
   localparam logic [7:0] WE [8] = '{8'h83, 8'h74, 8'h00, 8'h7F, 8'h00, 8'h03, 8'h43, 8'hF4};
   logic mclk;
   logic sys_rst;
   rpl_pkg::rpl_acc_t acc;
   logic [7:0] reg_rdata, enc_pkt_info, link_info, eq_setting;
   logic enc_pkt_valid, enc_pkt_crc_ok, raw_mode, raw_frame_marker, frame_begin_packet;
   logic local_selftest;
   logic [6:0] pin_output_mode, pulldown_on;
   logic [1:0] remote_selftest_active, selftest_mismatch, bc_frame_start, bc_bit_flip;
   logic [1:0] rx_lock, st_req, send_req;
   int n_fail;
   int n_compared;
   int k;
   int n_steps;

   rpl_port_regs #(.EQ_WAIT_BASE_CYC(BASE)) uut (.mclk(mclk), .sys_rst(sys_rst), .acc(acc),
      .reg_rdata(reg_rdata), .enc_pkt_valid(enc_pkt_valid), .enc_pkt_crc_ok(enc_pkt_crc_ok),
      .enc_pkt_info(enc_pkt_info), .link_info(link_info), .raw_mode(raw_mode),
      .raw_frame_marker(raw_frame_marker), .frame_begin_packet(frame_begin_packet),
      .pin_output_mode(pin_output_mode), .pulldown_on(pulldown_on),
      .local_selftest(local_selftest), .remote_selftest_active(remote_selftest_active),
      .selftest_mismatch(selftest_mismatch), .bc_frame_start(bc_frame_start),
      .bc_bit_flip(bc_bit_flip), .rx_lock(rx_lock), .eq_setting(eq_setting));

   rpl_remote_ser ser (.mclk(mclk), .selftest_req(st_req), .send_req(send_req),
      .remote_selftest_active(remote_selftest_active), .bc_frame_start(bc_frame_start));

   // 25 MHz clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // strobes rise after a falling edge and drop after the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      acc.wr = 1'b1;
      acc.addr = a;
      acc.wdata = d;
      @(negedge mclk);
      acc.wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
      @(negedge mclk);
      acc.rd = 1'b1;
      acc.addr = a;
      @(negedge mclk);
      acc.rd = 1'b0;
      chk(n, e, reg_rdata);
   endtask : rd

   task automatic pkt(input logic ok, input logic [7:0] info, input logic [7:0] e);
      @(negedge mclk);
      enc_pkt_valid = 1'b1;
      enc_pkt_crc_ok = ok;
      enc_pkt_info = info;
      @(negedge mclk);
      enc_pkt_valid = 1'b0;
      chk("link_info", e, link_info);
   endtask : pkt

   // partner raises the start one cycle later, flip shows one cycle on
   task automatic frame(input logic [1:0] p, input logic [1:0] e);
      @(negedge mclk);
      send_req = p;
      @(negedge mclk);
      send_req = 2'b00;
      @(negedge mclk);
      chk("bc_bit_flip", {6'h00, e}, {6'h00, bc_bit_flip});
   endtask : frame

   // counts edges until port 0 setting moves, bounded so a stuck stepper ends
   task automatic wait_step(output int n);
      logic [3:0] s;
      s = eq_setting[3:0];
      n = 0;
      while (eq_setting[3:0] === s && n < 100) begin
         @(negedge mclk);
         n++;
      end
   endtask : wait_step

   task automatic report_and_stop();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop

   // hang guard, far beyond the few hundred cycles the sequence needs
   initial begin
      #400000;
      n_fail++;
      report_and_stop();
   end

   initial begin
      sys_rst = 1'b1;
      acc = '0;
      enc_pkt_valid = 1'b0;
      enc_pkt_crc_ok = 1'b0;
      enc_pkt_info = 8'h00;
      raw_mode = 1'b0;
      raw_frame_marker = 1'b0;
      pin_output_mode = 7'h00;
      local_selftest = 1'b0;
      rx_lock = 2'b00;
      st_req = 2'b00;
      send_req = 2'b00;
      n_fail = 0;
      n_compared = 0;
      repeat (2) @(negedge mclk);
      sys_rst = 1'b0;
      chk("eq_setting", 8'h22, eq_setting);
      chk("pulldown_on", 8'h7F, {1'b0, pulldown_on});
      for (k = 0; k < 12; k++) rd(RA[k], RV[k], "reset value");
      // reserved and read-only bits must shrug off writes
      for (k = 0; k < 8; k++) begin
         wr(WA[k], WD[k]);
         rd(WA[k], WE[k], "write mask");
      end
      wr(8'hBA, 8'h03);
      wr(8'hBE, 8'h00);
      wr(8'hD0, 8'h00);
      // equalizer stepping, broadcast to both ports, wait code 0 then 1
      wr(8'h4C, 8'h03);
      for (k = 0; k < 2; k++) begin
         wr(8'hD2, 8'h1C | (k[7:0] << 5));
         chk("eq restart", 8'h22, eq_setting);
         wait_step(n_steps);
         chk("eq step wait", 8'(BASE << k), 8'(n_steps));
      end
      wr(8'hD2, 8'h3C);
      rd(8'hD2, 8'h34, "restart self clear");
      begin : step_time
         int n;
         wait_step(n);
         wait_step(n);
         chk("eq step wait", 8'(BASE << 1), 8'(n));
      end
      @(negedge mclk);
      rx_lock = 2'b01;
      repeat (2) @(negedge mclk);
      chk("first lock", 8'h00, {4'h0, eq_setting[3:0]});
      rx_lock = 2'b11;
      repeat (2) @(negedge mclk);
      wr(8'h4C, 8'h01);
      wr(8'hD5, 8'hF5);
      wr(8'hD2, 8'h0C);
      chk("floor start", 8'h05, eq_setting);
      wr(8'hD2, 8'h00);
      wr(8'hD2, 8'h08);
      chk("zero start", 8'h00, eq_setting);
      // encoder packets with the check on, then off
      pkt(1'b0, 8'hA5, 8'h00);
      pkt(1'b1, 8'h5A, 8'h5A);
      wr(8'hBA, 8'h80);
      pkt(1'b0, 8'hA5, 8'hA5);
      wr(8'hBA, 8'h03);
      // raw marker held high past the programmed count
      wr(8'hBC, 8'h03);
      @(negedge mclk);
      raw_mode = 1'b1;
      raw_frame_marker = 1'b1;
      for (k = 1; k < 7; k++) begin
         @(negedge mclk);
         chk("frame_begin_packet", {7'h00, k == 3}, {7'h00, frame_begin_packet});
      end
      raw_frame_marker = 1'b0;
      raw_mode = 1'b0;
      // pulldowns follow output mode and disable bits
      pin_output_mode = 7'h05;
      wr(8'hBE, 8'h12);
      @(negedge mclk);
      chk("pulldown_on", 8'h68, {1'b0, pulldown_on});
      wr(8'hBE, 8'h40);
      @(negedge mclk);
      chk("pulldown_on", 8'h3A, {1'b0, pulldown_on});
      // remote self-test on port 1 only
      st_req = 2'b10;
      repeat (3) @(negedge mclk);
      chk("selftest_mismatch", 8'h02, {6'h00, selftest_mismatch});
      wr(8'h4C, 8'h10);
      rd(8'hD0, 8'h20, "selftest flag");
      wr(8'h4C, 8'h00);
      rd(8'hD0, 8'h00, "selftest flag");
      local_selftest = 1'b1;
      repeat (2) @(negedge mclk);
      chk("selftest_mismatch", 8'h00, {6'h00, selftest_mismatch});
      st_req = 2'b00;
      // single injection on port 0, then continuous on port 1
      wr(8'h4C, 8'h01);
      wr(8'hD0, 8'h01);
      frame(2'b01, 2'b01);
      frame(2'b01, 2'b00);
      frame(2'b10, 2'b00);
      wr(8'hD0, 8'h00);
      wr(8'hD0, 8'h01);
      frame(2'b01, 2'b01);
      wr(8'hD0, 8'h00);
      wr(8'h4C, 8'h02);
      wr(8'hD0, 8'h02);
      frame(2'b11, 2'b10);
      frame(2'b10, 2'b10);
      report_and_stop();
   end
endmodule : rpl_port_regs_tb
